// ===== design/fmr_regbank.sv
// Purpose: Holding register bank of a pulse input flow meter behind a Modbus RTU slave
// Assumes: Frames are decoded outside; one register access per request, inputs synchronous
// Notes:   Answer one cycle after the request; broadcasts execute silently
`timescale 1ns/1ns
`include "fmr_consts.svh"

// Overview of operation
// - 32-bit values: high word first, low second
// - Pair write checked, partner word fixed up
// - Unfixable pair write: unchanged, exception 03h
// - Measurement read-only at 01h/02h, 0..999999
// - Status 03h: 0 valid, 20h wait, A0h alarm
// - 04h aliases precision 12h, range 0..5
// - 05h reads relays bits 0,1, alarm bit 4
// - Active current setpoint 1/256 mA, 0..1800h
// - Passive current setpoint 2CCh..1800h
// - Voltage setpoint 1/512 V, 0..1600h
// - Peak value read-only at 07h/08h
// - Total flow split over 09h..0Ch
// - Batcher split over 0Dh..0Fh
// - Read 03h, write 06h/10h, max 16
// - Numbers held in two's complement form
// - Broadcasts executed but never answered
module fmr_regbank
  import fmr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Decoded Modbus request
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [7:0] req_count,
  input wire logic req_broadcast,
  input wire logic [7:0] req_addr,
  input wire logic [15:0] req_wdata,
  // Answer to the frame layer
  output logic rsp_valid,
  output logic rsp_exception,
  output logic [7:0] rsp_exc_code,
  output logic [15:0] rsp_rdata,
  // Measurement front end
  input wire logic [19:0] meas_value,
  input wire logic meas_waiting,
  input wire logic meas_alarm,
  input wire logic [19:0] peak_value,
  input wire logic [31:0] total_thousands,
  input wire logic [9:0] total_units,
  input wire logic [9:0] total_thousandths,
  input wire logic [15:0] batch_thousands,
  input wire logic [9:0] batch_units,
  input wire logic [9:0] batch_thousandths,
  input wire fmr_out_e out_type,
  // Controlled outputs
  output logic first_relay,
  output logic second_relay,
  output logic [15:0] out_setpoint,
  output logic [2:0] flow_display_precision,
  output logic [31:0] pulse_factor
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Setpoint range check, used on every write path to the setpoint
  // An unknown output kind has no legal range, so every write is refused
  function automatic logic sp_legal(input fmr_out_e kind, input logic [15:0] v);
    logic ok;
    ok = 1'b0;
    case (kind)
      FMR_OUT_ACTIVE_CUR: ok = (v <= `FMR_SP_ACUR_MAX);
      FMR_OUT_PASSIVE_CUR: ok = (v >= `FMR_SP_PCUR_MIN) && (v <= `FMR_SP_PCUR_MAX);
      FMR_OUT_VOLTAGE: ok = (v <= `FMR_SP_VOLT_MAX);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Read-only offsets, used only by the write refusal; the read mux decodes on its own
  function automatic logic is_ro(input logic [7:0] a);
    return (a >= `FMR_OFF_MEAS_HI && a <= `FMR_OFF_STATUS) ||
           (a >= `FMR_OFF_PEAK_HI && a <= `FMR_OFF_BAT_MILLI);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic rsp_valid_reg, rsp_valid_next;
  logic rsp_exc_reg, rsp_exc_next;
  logic [7:0] rsp_code_reg, rsp_code_next;
  logic [15:0] rsp_data_reg, rsp_data_next;
  logic relay1_reg, relay1_next;
  logic relay2_reg, relay2_next;
  logic [15:0] sp_reg, sp_next;
  logic [2:0] prec_reg, prec_next;
  logic [31:0] factor_reg, factor_next;
  // Low words latched when the high word is read, so a pair read is coherent
  // A low read with no high read before it returns the previous latch
  logic [15:0] meas_lo_reg, meas_lo_next;
  logic [15:0] peak_lo_reg, peak_lo_next;
  logic [15:0] tot_lo_reg, tot_lo_next;

  // Combinational helpers
  logic [15:0] rd_word;
  logic rd_hit;
  logic [7:0] exc;
  logic [31:0] pair_new;

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Fields are unsigned and narrower than a word, so zero fill is
  // also their two's complement form
  always_comb begin
    rd_hit = 1'b1;
    rd_word = 16'h0000;
    // Unmapped numbers fall to the default and raise an address exception
    case (req_addr)
      `FMR_OFF_MEAS_HI: rd_word = {12'h000, meas_value[19:16]};
      `FMR_OFF_MEAS_LO: rd_word = meas_lo_reg;
      `FMR_OFF_STATUS: begin
        // Alarm outranks the wait state
        if (meas_alarm) begin
          rd_word = `FMR_STAT_ALARM;
        end else if (meas_waiting) begin
          rd_word = `FMR_STAT_WAIT;
        end else begin
          rd_word = `FMR_STAT_VALID;
        end
      end
      `FMR_OFF_PREC_ALIAS, `FMR_OFF_PREC: rd_word = {13'h0000, prec_reg};
      `FMR_OFF_RELAY: begin
        rd_word[`FMR_RELAY1_BIT] = relay1_reg;
        rd_word[`FMR_RELAY2_BIT] = relay2_reg;
        rd_word[`FMR_ALARM_BIT] = meas_alarm;
      end
      `FMR_OFF_SETPOINT: rd_word = sp_reg;
      `FMR_OFF_PEAK_HI: rd_word = {12'h000, peak_value[19:16]};
      `FMR_OFF_PEAK_LO: rd_word = peak_lo_reg;
      `FMR_OFF_TOT_K_HI: rd_word = total_thousands[31:16];
      `FMR_OFF_TOT_K_LO: rd_word = tot_lo_reg;
      `FMR_OFF_TOT_UNIT: rd_word = {6'h00, total_units};
      `FMR_OFF_TOT_MILLI: rd_word = {6'h00, total_thousandths};
      `FMR_OFF_BAT_K: rd_word = batch_thousands;
      `FMR_OFF_BAT_UNIT: rd_word = {6'h00, batch_units};
      `FMR_OFF_BAT_MILLI: rd_word = {6'h00, batch_thousandths};
      `FMR_OFF_FACTOR_HI: rd_word = factor_reg[31:16];
      `FMR_OFF_FACTOR_LO: rd_word = factor_reg[15:0];
      default: rd_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Request handling
  // ----------------------------------------------------------------
  // Exceptions are decided first; a refused write changes no storage
  // Refusal order: function, count, address, read-only target, value
  // The count is the whole frame's, checked again on each access of a group
  always_comb begin
    rsp_valid_next = 1'b0;
    rsp_exc_next = 1'b0;
    rsp_code_next = 8'h00;
    rsp_data_next = rsp_data_reg;
    relay1_next = relay1_reg;
    relay2_next = relay2_reg;
    sp_next = sp_reg;
    prec_next = prec_reg;
    factor_next = factor_reg;
    meas_lo_next = meas_lo_reg;
    peak_lo_next = peak_lo_reg;
    tot_lo_next = tot_lo_reg;
    exc = 8'h00;
    pair_new = factor_reg;
    if (req_valid) begin
      if (req_func != `FMR_FN_READ && req_func != `FMR_FN_WRITE_ONE &&
          req_func != `FMR_FN_WRITE_MANY) begin
        exc = `FMR_EXC_FUNC;
      end else if (req_count == 8'h00 || req_count > `FMR_MAX_GROUP) begin
        exc = `FMR_EXC_VALUE;
      end else if (!rd_hit) begin
        exc = `FMR_EXC_ADDR;
      end else if (req_func == `FMR_FN_READ) begin
        rsp_data_next = rd_word;
        // Freeze the partner word so the master sees one sample
        if (req_addr == `FMR_OFF_MEAS_HI) begin
          meas_lo_next = meas_value[15:0];
        end
        if (req_addr == `FMR_OFF_PEAK_HI) begin
          peak_lo_next = peak_value[15:0];
        end
        if (req_addr == `FMR_OFF_TOT_K_HI) begin
          tot_lo_next = total_thousands[15:0];
        end
      end else if (is_ro(req_addr)) begin
        exc = `FMR_EXC_ADDR;
      end else begin
        case (req_addr)
          `FMR_OFF_PREC_ALIAS, `FMR_OFF_PREC: begin
            if (req_wdata <= `FMR_PREC_MAX) begin
              prec_next = req_wdata[2:0];
            end else begin
              exc = `FMR_EXC_VALUE;
            end
          end
          `FMR_OFF_RELAY: begin
            // Bits above 1, the alarm bit too, are dropped; the alarm is not writable
            relay1_next = req_wdata[`FMR_RELAY1_BIT];
            relay2_next = req_wdata[`FMR_RELAY2_BIT];
          end
          `FMR_OFF_SETPOINT: begin
            if (sp_legal(out_type, req_wdata)) begin
              sp_next = req_wdata;
            end else begin
              exc = `FMR_EXC_VALUE;
            end
          end
          `FMR_OFF_FACTOR_HI: begin
            // Clamp the low word when the new high word allows it
            pair_new = {req_wdata, factor_reg[15:0]};
            if (pair_new > `FMR_PAIR_MAX) begin
              pair_new[15:0] = 16'(`FMR_PAIR_MAX & 32'h0000FFFF);
            end
            if (pair_new > `FMR_PAIR_MAX) begin
              exc = `FMR_EXC_VALUE;
            end else begin
              factor_next = pair_new;
            end
          end
          `FMR_OFF_FACTOR_LO: begin
            // Lowering the high word by one always lands in range
            // Lowering the partner keeps the written word, at the cost of a silent change
            pair_new = {factor_reg[31:16], req_wdata};
            if (pair_new > `FMR_PAIR_MAX) begin
              pair_new[31:16] = pair_new[31:16] - 16'h0001;
            end
            if (pair_new > `FMR_PAIR_MAX) begin
              exc = `FMR_EXC_VALUE;
            end else begin
              factor_next = pair_new;
            end
          end
          default: exc = `FMR_EXC_ADDR;
        endcase
      end
      // Broadcasts act on storage but stay silent
      // A refused broadcast leaves no trace, since no master waits for it
      rsp_valid_next = !req_broadcast;
      rsp_exc_next = !req_broadcast && (exc != 8'h00);
      rsp_code_next = req_broadcast ? 8'h00 : exc;
    end
  end

  // Register stage; reset is synchronous, so every reset value is a constant
  // Latched low words clear too, so a first low read returns zero
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rsp_valid_reg <= 1'b0;
      rsp_exc_reg <= 1'b0;
      rsp_code_reg <= 8'h00;
      rsp_data_reg <= 16'h0000;
      relay1_reg <= 1'b0;
      relay2_reg <= 1'b0;
      sp_reg <= `FMR_SP_RST;
      prec_reg <= `FMR_PREC_RST;
      factor_reg <= `FMR_FACTOR_RST;
      meas_lo_reg <= 16'h0000;
      peak_lo_reg <= 16'h0000;
      tot_lo_reg <= 16'h0000;
    end else begin
      rsp_valid_reg <= rsp_valid_next;
      rsp_exc_reg <= rsp_exc_next;
      rsp_code_reg <= rsp_code_next;
      rsp_data_reg <= rsp_data_next;
      relay1_reg <= relay1_next;
      relay2_reg <= relay2_next;
      sp_reg <= sp_next;
      prec_reg <= prec_next;
      factor_reg <= factor_next;
      meas_lo_reg <= meas_lo_next;
      peak_lo_reg <= peak_lo_next;
      tot_lo_reg <= tot_lo_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  // Answer fields mean something only in the cycle that rsp_valid is high
  assign rsp_valid = rsp_valid_reg;
  assign rsp_exception = rsp_exc_reg;
  assign rsp_exc_code = rsp_code_reg;
  assign rsp_rdata = rsp_data_reg;
  assign first_relay = relay1_reg;
  assign second_relay = relay2_reg;
  assign out_setpoint = sp_reg;
  assign flow_display_precision = prec_reg;
  assign pulse_factor = factor_reg;

endmodule

// ===== pkg/fmr_consts.svh
// Purpose: Offsets, field positions, reset values and limits of the flow meter register bank
// Assumes: Included by its bare name from the design
// Notes:   Definitions only
`ifndef FMR_CONSTS_SVH
`define FMR_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets (Modbus holding register numbers)
// ----------------------------------------------------------------
`define FMR_OFF_MEAS_HI 8'h01
`define FMR_OFF_MEAS_LO 8'h02
`define FMR_OFF_STATUS 8'h03
`define FMR_OFF_PREC_ALIAS 8'h04
`define FMR_OFF_RELAY 8'h05
`define FMR_OFF_SETPOINT 8'h06
`define FMR_OFF_PEAK_HI 8'h07
`define FMR_OFF_PEAK_LO 8'h08
`define FMR_OFF_TOT_K_HI 8'h09
`define FMR_OFF_TOT_K_LO 8'h0A
`define FMR_OFF_TOT_UNIT 8'h0B
`define FMR_OFF_TOT_MILLI 8'h0C
`define FMR_OFF_BAT_K 8'h0D
`define FMR_OFF_BAT_UNIT 8'h0E
`define FMR_OFF_BAT_MILLI 8'h0F
`define FMR_OFF_PREC 8'h12
`define FMR_OFF_FACTOR_HI 8'h16
`define FMR_OFF_FACTOR_LO 8'h17

// ----------------------------------------------------------------
// Function and exception codes
// ----------------------------------------------------------------
`define FMR_FN_READ 8'h03
`define FMR_FN_WRITE_ONE 8'h06
`define FMR_FN_WRITE_MANY 8'h10
`define FMR_EXC_FUNC 8'h01
`define FMR_EXC_ADDR 8'h02
`define FMR_EXC_VALUE 8'h03
`define FMR_MAX_GROUP 8'h10

// ----------------------------------------------------------------
// Status codes and relay field positions
// ----------------------------------------------------------------
`define FMR_STAT_VALID 16'h0000
`define FMR_STAT_WAIT 16'h0020
`define FMR_STAT_ALARM 16'h00A0
`define FMR_RELAY1_BIT 0
`define FMR_RELAY2_BIT 1
`define FMR_ALARM_BIT 4

// ----------------------------------------------------------------
// Ranges and reset values
// ----------------------------------------------------------------
`define FMR_PREC_MAX 16'h0005
`define FMR_SP_ACUR_MIN 16'h0000
`define FMR_SP_ACUR_MAX 16'h1800
`define FMR_SP_PCUR_MIN 16'h02CC
`define FMR_SP_PCUR_MAX 16'h1800
`define FMR_SP_VOLT_MIN 16'h0000
`define FMR_SP_VOLT_MAX 16'h1600
`define FMR_PAIR_MAX 32'h000F423F
`define FMR_PREC_RST 3'h0
`define FMR_SP_RST 16'h02CC
`define FMR_FACTOR_RST 32'h00000000

`endif

// ===== pkg/fmr_pkg.sv
// Purpose: Types shared by the flow meter register bank
// Assumes: fmr_consts.svh holds every number
// Notes:   Types only
package fmr_pkg;

  // Analog output kind selects the setpoint scale and range
  typedef enum logic [1:0] {
    FMR_OUT_ACTIVE_CUR = 2'b00,
    FMR_OUT_PASSIVE_CUR = 2'b01,
    FMR_OUT_VOLTAGE = 2'b10
  } fmr_out_e;

  typedef logic [15:0] fmr_word_t;

endpackage

// ===== testbench/fmr_regbank_assertions.sv
// Purpose: Port checker for the register bank
// Assumes: One clock, synchronous active low reset
// Notes:   Bound from the testbench top file
`timescale 1ns/1ns
module fmr_regbank_chk
  import fmr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Request
  input wire logic req_valid,
  input wire logic [7:0] req_func,
  input wire logic [7:0] req_count,
  input wire logic req_broadcast,
  input wire logic [7:0] req_addr,
  input wire logic [15:0] req_wdata,
  // Answer
  input wire logic rsp_valid,
  input wire logic rsp_exception,
  input wire logic [7:0] rsp_exc_code,
  input wire logic [15:0] rsp_rdata,
  // Front end and controlled state
  input wire logic [19:0] meas_value,
  input wire logic meas_waiting,
  input wire logic meas_alarm,
  input wire fmr_out_e out_type,
  input wire logic first_relay,
  input wire logic second_relay,
  input wire logic [15:0] out_setpoint,
  input wire logic [2:0] flow_display_precision,
  input wire logic [31:0] pulse_factor
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Addressed request; broadcasts are answered by nobody
  logic go;
  assign go = req_valid && !req_broadcast;
  sequence s_rd(logic [7:0] a);
    go && req_func == 8'h03 && req_count == 8'h01 && req_addr == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    go && req_func == 8'h06 && req_count == 8'h01 && req_addr == a;
  endsequence
  property p_answer; go |=> rsp_valid; endproperty
  a_answer: assert property (p_answer) else $error("request not answered");
  property p_silent; !go |=> !rsp_valid; endproperty
  a_silent: assert property (p_silent) else $error("answer without request");
  property p_func;
    go && !(req_func inside {8'h03, 8'h06, 8'h10}) |=> rsp_exception && rsp_exc_code == 8'h01;
  endproperty
  a_func: assert property (p_func) else $error("bad function accepted");
  property p_status;
    s_rd(8'h03) |=> rsp_rdata == ($past(meas_alarm) ? 16'h00A0 :
      $past(meas_waiting) ? 16'h0020 : 16'h0000);
  endproperty
  a_status: assert property (p_status) else $error("wrong status code");
  // Low word must come from the moment the high word was read
  property p_pair; s_rd(8'h01) ##1 s_rd(8'h02) |=> rsp_rdata == $past(meas_value[15:0], 2);
  endproperty
  a_pair: assert property (p_pair) else $error("incoherent pair read");
  property p_ro;
    go && req_func == 8'h06 && req_addr inside {[8'h01:8'h03], [8'h07:8'h0F]}
      |=> rsp_exception && rsp_exc_code == 8'h02;
  endproperty
  a_ro: assert property (p_ro) else $error("read-only write accepted");
  property p_relay; s_wr(8'h05) |=> !rsp_exception && first_relay == $past(req_wdata[0])
    && second_relay == $past(req_wdata[1]);
  endproperty
  a_relay: assert property (p_relay) else $error("relay write wrong");
  property p_prec; (s_wr(8'h04) ##0 (req_wdata > 16'h0005))
    |=> rsp_exc_code == 8'h03 && $stable(flow_display_precision);
  endproperty
  a_prec: assert property (p_prec) else $error("precision out of range taken");
  property p_sp; $changed(out_setpoint) |-> (out_type == FMR_OUT_PASSIVE_CUR ?
    out_setpoint inside {[16'h02CC:16'h1800]} :
    out_setpoint <= (out_type == FMR_OUT_VOLTAGE ? 16'h1600 : 16'h1800));
  endproperty
  a_sp: assert property (p_sp) else $error("setpoint out of range");
  property p_unfix; (s_wr(8'h16) ##0 (req_wdata > 16'h000F))
    |=> rsp_exc_code == 8'h03 && $stable(pulse_factor);
  endproperty
  a_unfix: assert property (p_unfix) else $error("unfixable pair changed");
endmodule

// ===== testbench/fmr_master_model.sv
// Purpose: Request side of a bus master after frame decoding
// Assumes: Caller spaces requests; back to back is legal
// Notes:   Released address and data go to their inverse so stale data is not trusted
`timescale 1ns/1ns
module fmr_master_model (
  // Clock
  input wire logic clk_sys,
  // Request to the bank
  output logic req_valid,
  output logic [7:0] req_func,
  output logic [7:0] req_count,
  output logic req_broadcast,
  output logic [7:0] req_addr,
  output logic [15:0] req_wdata
);
  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  initial begin
    {req_valid, req_broadcast, req_func, req_count, req_addr, req_wdata} = '0;
  end
  // One access, held for the single edge that takes it
  task automatic send(input logic [7:0] f, c, a, input logic [15:0] d, input logic b);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    {req_func, req_count, req_addr, req_wdata, req_broadcast} <= {f, c, a, d, b};
  endtask
  task automatic rest;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    {req_addr, req_wdata} <= ~{req_addr, req_wdata};
  endtask
endmodule

// ===== testbench/tb_fmr_regbank.sv
// Purpose: Self-checking bench for the register bank
// Assumes: Answer one cycle after each taken request that is not a broadcast
// Notes:   Driver queues expectations, a monitor pops them
`timescale 1ns/1ns
module tb_fmr_regbank;
  import fmr_pkg::*;
  // ----------------------------------------------------------------
  // Signals and harness
  // ----------------------------------------------------------------
  typedef struct packed {logic rd; logic exc; logic [7:0] code; logic [15:0] data;} fmr_exp_s;
  logic clk_sys = 1'b0;
  logic rstn, req_valid, req_broadcast, meas_waiting, meas_alarm;
  logic [7:0] req_func, req_count, req_addr, rsp_exc_code;
  logic [15:0] req_wdata, rsp_rdata, out_setpoint, batch_thousands, lo, hi;
  logic [19:0] meas_value, peak_value, v, pk;
  logic [31:0] total_thousands, pulse_factor, r;
  logic [9:0] total_units, total_thousandths, batch_units, batch_thousandths;
  logic rsp_valid, rsp_exception, first_relay, second_relay;
  logic [2:0] flow_display_precision;
  fmr_out_e out_type;
  fmr_exp_s q[$];
  fmr_exp_s e;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  integer seed = 32'h09EB5E19;
  always #10 clk_sys = ~clk_sys;
  fmr_master_model fmr_master_model_i (.clk_sys, .req_valid, .req_func, .req_count,
    .req_broadcast, .req_addr, .req_wdata);
  fmr_regbank fmr_regbank_i (.clk_sys, .rstn, .req_valid, .req_func, .req_count,
    .req_broadcast, .req_addr, .req_wdata, .rsp_valid, .rsp_exception, .rsp_exc_code,
    .rsp_rdata, .meas_value, .meas_waiting, .meas_alarm, .peak_value, .total_thousands,
    .total_units, .total_thousandths, .batch_thousands, .batch_units, .batch_thousandths,
    .out_type, .first_relay, .second_relay, .out_setpoint, .flow_display_precision,
    .pulse_factor);
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Request plus its note; the note lands before the answer can
  task automatic op(input logic [7:0] f, c, a, input logic [15:0] d, input fmr_exp_s x);
    fmr_master_model_i.send(f, c, a, d, 1'b0);
    q.push_back(x);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] d);
    op(8'h03, 8'h01, a, 16'h0000, {1'b1, 1'b0, 8'h00, d});
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [7:0] c);
    op(8'h06, 8'h01, a, d, {1'b0, c != 8'h00, c, 16'h0000});
  endtask
  task automatic settle;
    fmr_master_model_i.rest();
    fmr_master_model_i.rest();
  endtask
  // Monitor; an answer with no note is a spurious reply
  always @(negedge clk_sys) begin
    if (rstn === 1'b1 && rsp_valid === 1'b1) begin
      if (q.size() == 0) chk("spare answer", 1, 0);
      else begin
        e = q.pop_front();
        chk("exception", rsp_exception, e.exc);
        chk("code", rsp_exc_code, e.code);
        if (e.rd) chk("rdata", rsp_rdata, e.data);
      end
    end
  end
  // Hang guard, run is about 110 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    {meas_value, peak_value, total_thousands, total_units, total_thousandths} = '0;
    {batch_thousands, batch_units, batch_thousandths, meas_waiting, meas_alarm} = '0;
    out_type = FMR_OUT_ACTIVE_CUR;
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    chk("reset outs", {first_relay, second_relay, flow_display_precision, out_setpoint},
      {2'b00, 3'h0, 16'h02CC});
    chk("reset factor", pulse_factor, 32'h00000000);
    for (int i = 0; i < 3; i++) begin
      rd(8'h03, i == 2 ? 16'h00A0 : (i == 1 ? 16'h0020 : 16'h0000));
      // Status moves with the request, so the edge that takes it sees this value
      meas_waiting <= (i > 0);
      meas_alarm <= (i == 2);
    end
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      v = 20'(r % 32'd1000000);
      pk = i == 0 ? 20'hF423F : 20'(~r % 32'd1000000);
      r = $random(seed);
      // Let the standing request be taken before the values move under it
      fmr_master_model_i.rest();
      {meas_value, peak_value, total_thousands, batch_thousands} <= {v, pk, r, ~r[15:0]};
      {total_units, total_thousandths} <= {10'(r % 1000), 10'(r[31:16] % 1000)};
      {batch_units, batch_thousandths} <= {10'h3E7, 10'(r[15:6])};
      rd(8'h01, {12'h000, v[19:16]});
      rd(8'h02, v[15:0]);
      rd(8'h07, {12'h000, pk[19:16]});
      rd(8'h08, pk[15:0]);
      rd(8'h09, r[31:16]);
      rd(8'h0A, r[15:0]);
      rd(8'h0B, 16'(r % 1000));
      rd(8'h0C, 16'(r[31:16] % 1000));
      rd(8'h0D, ~r[15:0]);
      rd(8'h0E, 16'h03E7);
      rd(8'h0F, {6'h00, r[15:6]});
    end
    wr(8'h01, 16'h1234, 8'h02);
    wr(8'h0F, 16'h0000, 8'h02);
    op(8'h04, 8'h01, 8'h03, 16'h0000, {1'b0, 1'b1, 8'h01, 16'h0});
    op(8'h03, 8'h11, 8'h03, 16'h0000, {1'b0, 1'b1, 8'h03, 16'h0});
    op(8'h03, 8'h10, 8'h03, 16'h0000, {1'b1, 1'b0, 8'h00, 16'h00A0});
    rd(8'h11, 16'h0000);
    void'(q.pop_back());
    q.push_back({1'b0, 1'b1, 8'h02, 16'h0});
    wr(8'h04, 16'h0005, 8'h00);
    wr(8'h04, 16'h0006, 8'h03);
    rd(8'h12, 16'h0005);
    op(8'h10, 8'h02, 8'h12, 16'h0003, {1'b0, 1'b0, 8'h00, 16'h0});
    rd(8'h04, 16'h0003);
    wr(8'h05, 16'hFFFF, 8'h00);
    rd(8'h05, 16'h0013);
    wr(8'h05, 16'hFFEE, 8'h00);
    rd(8'h05, 16'h0012);
    settle();
    chk("relays prec", {first_relay, second_relay, flow_display_precision}, 5'b01011);
    for (int t = 0; t < 3; t++) begin
      out_type <= fmr_out_e'(t);
      lo = t == 1 ? 16'h02CC : 16'h0000;
      hi = t == 2 ? 16'h1600 : 16'h1800;
      wr(8'h06, hi, 8'h00);
      wr(8'h06, hi + 16'h0001, 8'h03);
      wr(8'h06, lo - 16'h0001, 8'h03);
      wr(8'h06, lo, 8'h00);
      settle();
      chk("setpoint", out_setpoint, lo);
    end
    out_type <= fmr_out_e'(2'b11);
    wr(8'h06, 16'h0100, 8'h03);
    fmr_master_model_i.rest();
    out_type <= FMR_OUT_ACTIVE_CUR;
    wr(8'h16, 16'h0010, 8'h03);
    wr(8'h16, 16'h000F, 8'h00);
    wr(8'h17, 16'hFFFF, 8'h00);
    settle();
    chk("pair fix low", pulse_factor, 32'h000EFFFF);
    wr(8'h16, 16'h000F, 8'h00);
    settle();
    chk("pair fix high", pulse_factor, 32'h000F423F);
    fmr_master_model_i.send(8'h06, 8'h01, 8'h06, 16'h0800, 1'b1);
    fmr_master_model_i.send(8'h06, 8'h01, 8'h06, 16'hFFFF, 1'b1);
    settle();
    chk("broadcast", out_setpoint, 16'h0800);
    settle();
    chk("notes left", q.size(), 0);
    print_verdict();
  end
endmodule
bind fmr_regbank fmr_regbank_chk fmr_regbank_chk_i (.clk_sys, .rstn, .req_valid, .req_func,
  .req_count, .req_broadcast, .req_addr, .req_wdata, .rsp_valid, .rsp_exception,
  .rsp_exc_code, .rsp_rdata, .meas_value, .meas_waiting, .meas_alarm, .out_type,
  .first_relay, .second_relay, .out_setpoint, .flow_display_precision, .pulse_factor);
